//--- rtl/plpp_pair_buf.sv
// Two-entry buffer for pixel words with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module plpp_pair_buf (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input plpp_pkg::plpp_word_t in_word_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output plpp_pkg::plpp_word_t out_word_o
);

    plpp_pkg::plpp_word_t slot_reg [2];
    logic head_reg;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic ready_reg;
    logic push;
    logic pop;
    logic wr_idx;

    assign push = in_valid_i && ready_reg;
    assign pop = out_valid_o && out_ready_i;
    assign wr_idx = head_reg ^ cnt_reg[0];
    assign cnt_next = 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
    assign out_valid_o = (cnt_reg != plpp_pkg::CNT_RST);
    assign out_word_o = slot_reg[head_reg];
    assign in_ready_o = ready_reg;

    ////////////////////////////////////////////////////////////////////////
    // Storage
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            slot_reg[wr_idx] <= in_word_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointers and occupancy
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            head_reg <= 1'b0;
            cnt_reg <= plpp_pkg::CNT_RST;
            ready_reg <= 1'b1;
        end else begin
            if (pop) begin
                head_reg <= ~head_reg;
            end
            cnt_reg <= cnt_next;
            ready_reg <= (cnt_next != 2'h2);
        end
    end

endmodule : plpp_pair_buf

//--- rtl/plpp_pkg.sv
// Shared types and constants of the passive panel port.
// Assumes a panel with no read-back path; every panel signal is an output.
package plpp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Geometry
    localparam int unsigned LANES = 16;
    localparam int unsigned HALF_LANES = 8;
    localparam int unsigned LEVEL_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned MONO_SINGLE_W = 4;
    localparam int unsigned MONO_DUAL_W = 8;
    localparam int unsigned COLOR_SINGLE_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // Timing and dither
    localparam logic [7:0] BIAS_LINES = 8'h0d;
    localparam logic [7:0] DITHER_FRAME_STEP = 8'h35;
    localparam logic [7:0] DITHER_LANE_STEP = 8'h11;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [1:0] CNT_RST = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Modes and states
    typedef enum logic [2:0] {
        MODE_MONO_SINGLE,
        MODE_MONO_DOUBLE,
        MODE_MONO_DUAL,
        MODE_COLOR_SINGLE,
        MODE_COLOR_DUAL
    } plpp_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FRAME,
        ST_DATA,
        ST_SHIFT,
        ST_LINE
    } plpp_state_t;

    // Lanes 0..7 feed the upper half or the whole panel, lanes 8..15 the lower half
    typedef struct packed {
        logic frame_start;
        logic line_end;
        logic [LANES-1:0][LEVEL_W-1:0] level;
    } plpp_word_t;

endpackage : plpp_pkg

//--- rtl/plpp_port.sv
// Passive monochrome and colour panel port: buffer, clock crossing, dither, strobes.
// Assumes pix_clk_i is the pixel clock made elsewhere in the controller, unrelated to sys_clk_i.
`timescale 1ns/100ps

// Overview of operation
// - Double-pixel monochrome mode drives eight data lines, one pixel each, twice the plain single-scan rate.
// - Double-pixel mode orders its eight pixels as two independent half-height panels.
// - Monochrome dual-scan drives eight pixels per transfer, four lines for the upper half and four for the lower.
// - Monochrome dual-scan sequences data as two half-height panels refreshed together.
// - Every colour mode sends dithered data instead of direct intensity values.
// - Colour single-scan drives eight lines of red, green and blue bits in groups of three.
// - Colour dual-scan drives sixteen lines, eight per half, five and one-third pixels per transfer.
// - Colour dual-scan gives each half-height panel its own eight-line slice.
// - The pixel strobe toggles once per transfer so the panel shifts in the data lines.
// - The line strobe pulses after the last pixel of each line.
// - The frame strobe is asserted at the start of each new frame.
// - The bias output toggles periodically so the panel reverses its drive polarity.
// - Data, pixel, line, frame and bias signals are outputs only; nothing is sampled from the panel.
// - Plain monochrome single-scan drives four data lines, one pixel each.
// - Monochrome modes take an 8-bit gray level per pixel and dither it onto one line.
module plpp_port (
    // Clocks and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic pix_clk_i,
    // Configuration
    input plpp_pkg::plpp_mode_t mode_i,
    // Pixel word stream
    input wire logic in_valid_i,
    output logic in_ready_o,
    input plpp_pkg::plpp_word_t in_word_i,
    // Panel pins
    output logic [15:0] panel_data_lines_o,
    output logic pixel_strobe_o,
    output logic line_strobe_o,
    output logic frame_strobe_o,
    output logic bias_o
);

    ////////////////////////////////////////////////////////////////////////
    // System side: buffer and request
    logic buf_valid;
    plpp_pkg::plpp_word_t buf_word;
    plpp_pkg::plpp_word_t hold_reg;
    logic req_reg;
    logic busy_reg;
    logic ack_s1_reg;
    logic ack_s2_reg;
    logic ack_reg;

    plpp_pair_buf u_buf (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .in_valid_i(in_valid_i),
        .in_ready_o(in_ready_o),
        .in_word_i(in_word_i),
        .out_valid_o(buf_valid),
        .out_ready_i(!busy_reg),
        .out_word_o(buf_word)
    );

    always_ff @(posedge sys_clk_i) begin
        if (buf_valid && !busy_reg) begin
            hold_reg <= buf_word;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            req_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else if (buf_valid && !busy_reg) begin
            req_reg <= ~req_reg;
            busy_reg <= 1'b1;
        end else if (busy_reg && (ack_s2_reg == req_reg)) begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            ack_s1_reg <= ack_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel side: reset, request and mode synchronisers
    logic rst_s1_reg;
    logic pix_rst;
    logic req_s1_reg;
    logic req_s2_reg;
    plpp_pkg::plpp_mode_t mode_s1_reg;
    plpp_pkg::plpp_mode_t mode_s2_reg;

    // Reset stretch: a short system reset is held until the pixel side has seen it
    logic prst_reg;
    logic prst_ack_s1_reg;
    logic prst_ack_s2_reg;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            prst_reg <= 1'b1;
        end else if (prst_ack_s2_reg) begin
            prst_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        prst_ack_s1_reg <= pix_rst;
        prst_ack_s2_reg <= prst_ack_s1_reg;
    end

    always_ff @(posedge pix_clk_i) begin
        rst_s1_reg <= prst_reg;
        pix_rst <= rst_s1_reg;
    end

    always_ff @(posedge pix_clk_i) begin
        if (pix_rst) begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            mode_s1_reg <= plpp_pkg::MODE_MONO_SINGLE;
            mode_s2_reg <= plpp_pkg::MODE_MONO_SINGLE;
        end else begin
            req_s1_reg <= req_reg;
            req_s2_reg <= req_s1_reg;
            mode_s1_reg <= mode_i;
            mode_s2_reg <= mode_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel side: sequencer
    plpp_pkg::plpp_state_t st_reg;
    plpp_pkg::plpp_word_t word_reg;
    logic [7:0] frame_cnt_reg;
    logic [7:0] pos_reg;
    logic [7:0] bias_cnt_reg;
    logic new_word;

    assign new_word = (req_s2_reg != ack_reg);

    always_ff @(posedge pix_clk_i) begin
        if (pix_rst) begin
            st_reg <= plpp_pkg::ST_IDLE;
            ack_reg <= 1'b0;
        end else begin
            unique case (st_reg)
                plpp_pkg::ST_IDLE: begin
                    if (new_word) begin
                        st_reg <= hold_reg.frame_start ? plpp_pkg::ST_FRAME : plpp_pkg::ST_DATA;
                    end
                end
                plpp_pkg::ST_FRAME: begin
                    st_reg <= plpp_pkg::ST_DATA;
                end
                plpp_pkg::ST_DATA: begin
                    st_reg <= plpp_pkg::ST_SHIFT;
                end
                plpp_pkg::ST_SHIFT: begin
                    if (word_reg.line_end) begin
                        st_reg <= plpp_pkg::ST_LINE;
                    end else begin
                        st_reg <= plpp_pkg::ST_IDLE;
                        ack_reg <= req_s2_reg;
                    end
                end
                plpp_pkg::ST_LINE: begin
                    st_reg <= plpp_pkg::ST_IDLE;
                    ack_reg <= req_s2_reg;
                end
            endcase
        end
    end

    always_ff @(posedge pix_clk_i) begin
        if ((st_reg == plpp_pkg::ST_IDLE) && new_word) begin
            word_reg <= hold_reg;
        end
    end

    always_ff @(posedge pix_clk_i) begin
        if (pix_rst) begin
            frame_cnt_reg <= 8'h00;
            pos_reg <= 8'h00;
        end else if (st_reg == plpp_pkg::ST_FRAME) begin
            frame_cnt_reg <= 8'(frame_cnt_reg + 8'h01);
            pos_reg <= 8'h00;
        end else if (st_reg == plpp_pkg::ST_SHIFT) begin
            pos_reg <= 8'(pos_reg + 8'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dither: each lane level compared with a moving threshold
    logic [15:0] dith;

    genvar gi;
    generate
        for (gi = 0; gi < plpp_pkg::LANES; gi = gi + 1) begin : g_dith
            logic [7:0] thr;
            assign thr = 8'(frame_cnt_reg * plpp_pkg::DITHER_FRAME_STEP
                          + 8'(gi) * plpp_pkg::DITHER_LANE_STEP + pos_reg);
            assign dith[gi] = (word_reg.level[gi] > thr);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Lane placement per mode
    logic [15:0] data_next;

    always_comb begin
        data_next = plpp_pkg::DATA_RST;
        unique case (mode_s2_reg)
            plpp_pkg::MODE_MONO_SINGLE: begin
                data_next[3:0] = dith[3:0];
            end
            plpp_pkg::MODE_MONO_DOUBLE: begin
                data_next[3:0] = dith[3:0];
                data_next[7:4] = dith[11:8];
            end
            plpp_pkg::MODE_MONO_DUAL: begin
                data_next[3:0] = dith[3:0];
                data_next[7:4] = dith[11:8];
            end
            plpp_pkg::MODE_COLOR_SINGLE: begin
                data_next[7:0] = dith[7:0];
            end
            plpp_pkg::MODE_COLOR_DUAL: begin
                data_next[15:8] = dith[7:0];
                data_next[7:0] = dith[15:8];
            end
            default: begin
                data_next = plpp_pkg::DATA_RST;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Panel outputs, all driven toward the panel
    always_ff @(posedge pix_clk_i) begin
        if (pix_rst) begin
            panel_data_lines_o <= plpp_pkg::DATA_RST;
        end else if (st_reg == plpp_pkg::ST_DATA) begin
            panel_data_lines_o <= data_next;
        end
    end

    always_ff @(posedge pix_clk_i) begin
        if (pix_rst) begin
            pixel_strobe_o <= 1'b0;
        end else if (st_reg == plpp_pkg::ST_SHIFT) begin
            pixel_strobe_o <= ~pixel_strobe_o;
        end
    end

    always_ff @(posedge pix_clk_i) begin
        if (pix_rst) begin
            line_strobe_o <= 1'b0;
        end else begin
            line_strobe_o <= (st_reg == plpp_pkg::ST_LINE);
        end
    end

    always_ff @(posedge pix_clk_i) begin
        if (pix_rst) begin
            frame_strobe_o <= 1'b0;
        end else begin
            frame_strobe_o <= (st_reg == plpp_pkg::ST_FRAME);
        end
    end

    always_ff @(posedge pix_clk_i) begin
        if (pix_rst) begin
            bias_o <= 1'b0;
            bias_cnt_reg <= 8'h00;
        end else if (st_reg == plpp_pkg::ST_LINE) begin
            if (bias_cnt_reg == 8'(plpp_pkg::BIAS_LINES - 8'h01)) begin
                bias_cnt_reg <= 8'h00;
                bias_o <= ~bias_o;
            end else begin
                bias_cnt_reg <= 8'(bias_cnt_reg + 8'h01);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence shift_s;
        st_reg == plpp_pkg::ST_SHIFT;
    endsequence

    sequence line_pulse_s;
        line_strobe_o ##1 !line_strobe_o;
    endsequence

    sequence data_s(plpp_pkg::plpp_mode_t m);
        (st_reg == plpp_pkg::ST_DATA) && (mode_s2_reg == m);
    endsequence

    pix_toggle_a: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        shift_s |=> $changed(pixel_strobe_o))
        else $error("pixel strobe did not toggle on transfer");

    pix_data_steady_a: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        $changed(pixel_strobe_o) |-> $stable(panel_data_lines_o))
        else $error("data moved with pixel strobe");

    line_after_last_a: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        (shift_s and word_reg.line_end) |-> ##2 line_pulse_s)
        else $error("line strobe missing after last pixel");

    line_only_end_a: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        (shift_s and !word_reg.line_end) |-> ##1 !line_strobe_o [*2])
        else $error("line strobe inside a line");

    frame_start_a: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        (st_reg == plpp_pkg::ST_FRAME) |=> frame_strobe_o ##1 !frame_strobe_o ##1 $changed(pixel_strobe_o))
        else $error("frame strobe not ahead of first transfer");

    mono_four_a: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        data_s(plpp_pkg::MODE_MONO_SINGLE) |=> (panel_data_lines_o[15:4] == 12'h000))
        else $error("mono single-scan drove unused lines");

    mono_double_a: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        data_s(plpp_pkg::MODE_MONO_DOUBLE) |=> (panel_data_lines_o[15:8] == 8'h00)
            && (panel_data_lines_o[7:0] == {$past(dith[11:8]), $past(dith[3:0])}))
        else $error("mono double-pixel lane placement wrong");

    mono_dual_a: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        data_s(plpp_pkg::MODE_MONO_DUAL) |=> (panel_data_lines_o[15:8] == 8'h00)
            && (panel_data_lines_o[7:4] == $past(dith[11:8])))
        else $error("mono dual-scan lane placement wrong");

    color_single_a: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        data_s(plpp_pkg::MODE_COLOR_SINGLE) |=> (panel_data_lines_o[15:8] == 8'h00))
        else $error("colour single-scan drove upper lines");

    color_dual_a: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        data_s(plpp_pkg::MODE_COLOR_DUAL) |=> (panel_data_lines_o == {$past(dith[7:0]), $past(dith[15:8])}))
        else $error("colour dual-scan halves misplaced");

    bias_period_a: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        ((st_reg == plpp_pkg::ST_LINE) && (bias_cnt_reg == 8'(plpp_pkg::BIAS_LINES - 8'h01)))
            |=> $changed(bias_o))
        else $error("bias did not toggle at period end");

    bias_hold_a: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        !((st_reg == plpp_pkg::ST_LINE) && (bias_cnt_reg == 8'(plpp_pkg::BIAS_LINES - 8'h01)))
            |=> $stable(bias_o))
        else $error("bias moved inside its period");

    handshake_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (busy_reg && $past(busy_reg)) |-> $stable(hold_reg))
        else $error("held word changed during crossing");

endmodule : plpp_port

//--- test/plpp_panel_model.sv
// Passive panel model: shifts data on pixel strobe toggles, counts line, frame and bias events.
// Assumes the panel only receives; it drives nothing back toward the port.
`timescale 1ns/100ps
module plpp_panel_model (
    // Link clock
    input wire logic pix_clk_i,
    // Panel pins
    input wire logic [15:0] panel_data_lines_i,
    input wire logic pixel_strobe_i,
    input wire logic line_strobe_i,
    input wire logic frame_strobe_i,
    input wire logic bias_i,
    // Observations
    output int xfer_cnt_o,
    output int line_cnt_o,
    output int frame_cnt_o,
    output int bias_cnt_o,
    output int lead_cnt_o,
    output int gap_o,
    output logic [15:0] data_o
);
    logic strobe_q = 1'b0;
    logic bias_q = 1'b0;
    logic frame_pend = 1'b0;
    int since = 0;
    initial begin
        {xfer_cnt_o, line_cnt_o, frame_cnt_o, bias_cnt_o, lead_cnt_o, gap_o} = '0;
        data_o = '0;
    end
    ////////////////////////////////////////////////////////////////
    // Shift, latch and polarity events; an unknown strobe counts as no event
    always @(posedge pix_clk_i) begin
        if (pixel_strobe_i != strobe_q) begin
            xfer_cnt_o++;
            data_o = panel_data_lines_i;
            if (frame_pend) lead_cnt_o++;
            frame_pend = 1'b0;
        end
        if (frame_strobe_i == 1'b1) begin
            frame_cnt_o++;
            frame_pend = 1'b1;
        end
        if (line_strobe_i == 1'b1) begin
            line_cnt_o++;
            since++;
        end
        if (bias_i != bias_q) begin
            bias_cnt_o++;
            gap_o = since;
            since = 0;
        end
        strobe_q = pixel_strobe_i;
        bias_q = bias_i;
    end
endmodule : plpp_panel_model

//--- test/tb_passive_lcd_panel_port.sv
// Self-checking bench of the passive panel port: lane mapping, dither, strobes, buffer, bias.
// Assumes the panel model of plpp_panel_model.sv on the far side.
`timescale 1ns/100ps
module tb_passive_lcd_panel_port;
    logic sys_clk = 1'b0, pix_clk = 1'b0, srst = 1'b1, in_valid = 1'b0, saw_full = 1'b0;
    logic in_ready, pix_stb, line_stb, frame_stb, bias;
    logic [15:0] lines, seen;
    plpp_pkg::plpp_mode_t mode = plpp_pkg::MODE_MONO_SINGLE;
    plpp_pkg::plpp_word_t in_word = '0;
    int xfers, nline, nframe, nbias, nlead, gap, base, tot = 0, error_cnt = 0, checks = 0, cyc = 0;
    plpp_pkg::plpp_mode_t modes [5] = '{plpp_pkg::MODE_MONO_SINGLE, plpp_pkg::MODE_MONO_DOUBLE,
        plpp_pkg::MODE_MONO_DUAL, plpp_pkg::MODE_COLOR_SINGLE, plpp_pkg::MODE_COLOR_DUAL};
    logic [15:0] up_m [5] = '{16'h000f, 16'h000f, 16'h000f, 16'h00ff, 16'hff00};
    logic [15:0] lo_m [5] = '{16'h0000, 16'h00f0, 16'h00f0, 16'h0000, 16'h00ff};
    always #4 sys_clk = ~sys_clk;
    initial begin
        #13;
        forever #80 pix_clk = ~pix_clk;
    end
    ////////////////////////////////////////////////////////////////
    plpp_port plpp_port_i (
        .sys_clk_i(sys_clk),
        .srst_i(srst),
        .pix_clk_i(pix_clk),
        .mode_i(mode),
        .in_valid_i(in_valid),
        .in_ready_o(in_ready),
        .in_word_i(in_word),
        .panel_data_lines_o(lines),
        .pixel_strobe_o(pix_stb),
        .line_strobe_o(line_stb),
        .frame_strobe_o(frame_stb),
        .bias_o(bias)
    );
    plpp_panel_model plpp_panel_model_i (
        .pix_clk_i(pix_clk),
        .panel_data_lines_i(lines),
        .pixel_strobe_i(pix_stb),
        .line_strobe_i(line_stb),
        .frame_strobe_i(frame_stb),
        .bias_i(bias),
        .xfer_cnt_o(xfers),
        .line_cnt_o(nline),
        .frame_cnt_o(nframe),
        .bias_cnt_o(nbias),
        .lead_cnt_o(nlead),
        .gap_o(gap),
        .data_o(seen)
    );
    ////////////////////////////////////////////////////////////////
    // Shared tasks
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    function plpp_pkg::plpp_word_t mk(input logic fs, input logic le, input logic [15:0] lm, input logic [7:0] lvl);
        mk = '0;
        mk.frame_start = fs;
        mk.line_end = le;
        for (int i = 0; i < 16; i++) if (lm[i]) mk.level[i] = lvl;
    endfunction : mk
    // Offer a word and hold it until taken; valid stays up for back-to-back use
    task push(input plpp_pkg::plpp_word_t w);
        in_word <= w;
        in_valid <= 1'b1;
        tot += w.line_end;
        do @(posedge sys_clk); while (in_ready !== 1'b1);
    endtask : push
    task stop;
        in_valid <= 1'b0;
        @(posedge sys_clk);
    endtask : stop
    // Wait for the panel to shift n words, then 100 more system clocks to cover any trailing line strobe
    task wait_xfer(input int n);
        while (xfers < n) @(posedge sys_clk);
        repeat (100) @(posedge sys_clk);
    endtask : wait_xfer
    task set_mode(input plpp_pkg::plpp_mode_t m);
        mode <= m;
        repeat (100) @(posedge sys_clk);
    endtask : set_mode
    always @(posedge sys_clk) if (in_valid && in_ready === 1'b0) saw_full <= 1'b1;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            $display("[ERR] run length expected below 40000 seen 40000");
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task t_reset;
        chk("in_ready after reset", 1, in_ready);
        chk("data lines after reset", 0, lines);
        chk("line frame bias after reset", 0, {line_stb, frame_stb, bias});
        $display("test reset done");
    endtask : t_reset
    task t_map;
        for (int m = 0; m < 5; m++) begin
            set_mode(modes[m]);
            base = xfers;
            push(mk(1'b1, 1'b0, 16'h00ff, 8'hff));
            stop();
            wait_xfer(base + 1);
            chk("upper lanes off map", 0, seen & ~up_m[m]);
            chk("upper lanes present", up_m[m] != 0, seen != 0);
            push(mk(1'b0, 1'b1, 16'hff00, 8'hff));
            stop();
            wait_xfer(base + 2);
            chk("lower lanes off map", 0, seen & ~lo_m[m]);
            chk("lower lanes present", lo_m[m] != 0, seen != 0);
        end
        chk("frame strobes", 5, nframe);
        chk("frame strobe before data", 5, nlead);
        chk("line strobes", 5, nline);
        $display("test mapping done");
    endtask : t_map
    task t_dither;
        set_mode(plpp_pkg::MODE_COLOR_DUAL);
        base = xfers;
        push(mk(1'b1, 1'b1, 16'hffff, 8'h80));
        stop();
        wait_xfer(base + 1);
        chk("mid level mixed bits", 1, seen != 0 && seen != 16'hffff);
        push(mk(1'b0, 1'b1, 16'hffff, 8'h00));
        stop();
        wait_xfer(base + 2);
        chk("dark level", 0, seen);
        $display("test dither done");
    endtask : t_dither
    task t_burst;
        base = xfers;
        for (int i = 0; i < 4; i++) push(mk(1'b0, 1'b1, 16'h000f, 8'hff));
        stop();
        wait_xfer(base + 4);
        chk("buffer refused when full", 1, saw_full);
        chk("pixel strobe toggles", base + 4, xfers);
        $display("test burst done");
    endtask : t_burst
    task t_bias;
        base = xfers;
        for (int i = 0; i < 28; i++) push(mk(1'b0, 1'b1, 16'h0000, 8'h00));
        stop();
        wait_xfer(base + 28);
        chk("line strobes total", tot, nline);
        chk("bias toggles", tot / 13, nbias);
        chk("lines between bias toggles", 13, gap);
        $display("test bias done");
    endtask : t_bias
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (100) @(posedge sys_clk);
        t_reset();
        t_map();
        t_dither();
        t_burst();
        t_bias();
        tally_and_finish();
    end
endmodule : tb_passive_lcd_panel_port
